//--- ppg_pkg.sv
// Package of constants and types for the power-path pin reload block
package ppg_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [7:0] OFS_PIN1_PRESET = 8'hEA;
  localparam logic [7:0] OFS_PIN2_PRESET = 8'hEB;
  localparam logic [7:0] OFS_PATH_EN = 8'hEC;
  localparam logic [7:0] OFS_PIN1_CTRL = 8'hED;
  localparam logic [7:0] OFS_PIN2_CTRL = 8'hEE;
  localparam logic [7:0] OFS_PIN3_CTRL = 8'hEF;
  localparam logic [7:0] OFS_PAGE = 8'hF2;
  localparam logic [7:0] OFS_CMD = 8'h23;
  localparam logic [7:0] OFS_OPTIONS = 8'hF0;
  // Command codes
  localparam logic [7:0] CMD_DIS_SNK = 8'h44;
  localparam logic [7:0] CMD_ENA_SNK = 8'h55;
  localparam logic [7:0] CMD_DIS_SRC = 8'h66;
  localparam logic [7:0] CMD_ENA_SRC = 8'h77;
  localparam logic [7:0] CMD_ENA_HV = 8'h88;
  // Preset register bit positions
  localparam int PRE_DIS_SNK = 0;
  localparam int PRE_ENA_SNK = 1;
  localparam int PRE_DIS_SRC = 2;
  localparam int PRE_ENA_SRC = 3;
  localparam int PRE_HV = 4;
  localparam int PRE_SWAP = 6;
  localparam logic [7:0] PRESET_MASK = 8'h5F;
  // Path enable register bit positions
  localparam int EN_PIN2_RELOAD = 7;
  localparam int EN_PIN1_RELOAD = 6;
  localparam int EN_GATE_B_RELOAD = 5;
  localparam int EN_GATE_A_RELOAD = 4;
  localparam int EN_GATE_B_LPOFF = 3;
  localparam int EN_GATE_A_LPOFF = 2;
  localparam int EN_GATE_B_PUMP = 1;
  localparam int EN_GATE_A_PUMP = 0;
  localparam logic [7:0] PATH_EN_RESET = 8'h3F;
  // Pin control register bit positions
  localparam int CTL_DEGLITCH = 7;
  localparam int CTL_HYST = 6;
  localparam int CTL_PULL_HIGH = 5;
  localparam int CTL_PULL_LOW = 4;
  localparam int CTL_DRIVE = 3;
  localparam int CTL_DIR = 2;
  localparam int CTL_OUT = 1;
  localparam int CTL_IN = 0;
  localparam logic [7:0] PIN_CTRL_RESET = 8'h00;
  localparam logic [7:0] PAGE_RESET = 8'h00;
  localparam logic [7:0] PRESET_RESET = 8'h00;
  // Options register bit positions
  localparam int OPT_SWAP_WAIT = 0;
  localparam int OPT_TO_PIN1 = 1;
  localparam int OPT_TO_PIN2 = 2;
  localparam logic [7:0] OPTIONS_RESET = 8'h00;
  localparam logic [7:0] OPTIONS_MASK = 8'h07;
  // Deglitch time
  localparam int CLK_MHZ = 100;
  localparam int DEGLITCH_NS = 3000;
  localparam int DEGLITCH_CYC = (DEGLITCH_NS * CLK_MHZ + 999) / 1000;
  typedef enum logic [2:0] {
    PPG_EV_NONE = 3'b000,
    PPG_EV_DIS_SNK = 3'b001,
    PPG_EV_ENA_SNK = 3'b010,
    PPG_EV_DIS_SRC = 3'b011,
    PPG_EV_ENA_SRC = 3'b100,
    PPG_EV_HV = 3'b101
  } ppg_event_t;
endpackage

//--- ppg_filt_if.sv
// Interface between the pin input filter and the main block
`timescale 1ns/100ps
interface ppg_filt_if;
  logic raw;
  logic deglitch_en;
  logic level;
  modport filt (input raw, input deglitch_en, output level);
  modport user (output raw, output deglitch_en, input level);
endinterface

//--- ppg_filter.sv
// Two-flop synchroniser and optional input deglitch for one pin
`timescale 1ns/100ps
module ppg_filter #(
  parameter int CYC = ppg_pkg::DEGLITCH_CYC
) (
  input wire logic ref_clk,
  input wire logic nrst,
  ppg_filt_if.filt f
);
  import ppg_pkg::*;
  localparam int CW = $clog2(CYC + 1);
  initial begin
    if (CYC < 1) $error("deglitch count must be at least one");
  end
  typedef struct packed {
    logic s1;
    logic s2;
    logic level;
    logic [CW-1:0] cnt;
  } ppg_filt_t;
  ppg_filt_t r;
  ppg_filt_t next_r;
  always_comb begin
    next_r = r;
    next_r.s1 = f.raw;
    next_r.s2 = r.s1;
    if (!f.deglitch_en) begin
      next_r.level = r.s2;
      next_r.cnt = '0;
    end else if (r.s2 == r.level) begin
      next_r.cnt = '0;
    end else if (r.cnt == CW'(CYC - 1)) begin
      // Level must differ for the full window before it is taken
      next_r.level = r.s2;
      next_r.cnt = '0;
    end else begin
      next_r.cnt = r.cnt + CW'(1);
    end
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
  assign f.level = r.level;
endmodule // ppg_filter

//--- ppg_gpio_reload.sv
// Pin control registers with automatic reload on power-path commands
//
// Added by the designer: the strobed register port.
`timescale 1ns/100ps
// Functional notes
// - Command 55h with reload on loads each pin's enable-sink preset.
// - Command 44h with reload on loads each pin's disable-sink preset.
// - Command 77h with reload on loads each pin's enable-source preset.
// - Command 66h with reload on loads each pin's disable-source preset.
// - Command 88h with reload on loads each pin's high-voltage preset.
// - Swap event with reload on loads pin two's preset bit 6.
// - Preset 0 gives push-pull low, 1 push-pull high; resets to 0.
// - Bits 7 and 6 enable reload for pins two and one; reset off.
// - Bits 5 and 4 enable gate B and A path reload; reset on.
// - Bits 1 and 0 enable gate B and A charge pumps; reset on.
// - Bits 3 and 2 shut the matching pump off in low power mode.
// - Control bit 7 adds a 3 us input deglitch; reset off.
// - Bits 6, 5, 4 enable hysteresis, pull-high, pull-low; reset off.
// - Bit 3 selects open-drain at 0 (reset) or push-pull at 1.
// - Bit 2 selects input at 0 (reset) or output at 1.
// - Bit 1 gives the driven level; resets low.
// - Bit 0 is read-only and returns the sampled pin level.
// - Register F2h is the second page select; resets to 00h.
// - Wait option delays swap reload until VBUS is below threshold.
// - Timeout option returns the pin to reset defaults on watchdog timeout.
module ppg_gpio_reload #(
  parameter int DEG_CYC = ppg_pkg::DEGLITCH_CYC
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [ppg_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [ppg_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [ppg_pkg::DATA_W-1:0] reg_rdata,
  input wire logic swap_event,
  input wire logic vbus_below_swap,
  input wire logic watchdog_timeout,
  input wire logic low_power_mode,
  input wire logic [2:0] pin_in,
  output logic [2:0] pin_out,
  output logic [2:0] pin_oe,
  output logic [2:0] pull_high_enable,
  output logic [2:0] pull_low_enable,
  output logic [2:0] input_hysteresis_enable,
  output logic gate_a_auto_reload_enable,
  output logic gate_b_auto_reload_enable,
  output logic gate_a_pump_enable,
  output logic gate_b_pump_enable,
  output logic [7:0] second_page_select
);
  import ppg_pkg::*;

  typedef struct packed {
    logic [7:0] pin1_pre;
    logic [7:0] pin2_pre;
    logic [7:0] path_en;
    logic [2:0][7:0] ctl;
    logic [7:0] page;
    logic [7:0] opts;
    logic swap_pend;
    logic [7:0] rdata;
    // Two-stage synchronisers for the asynchronous control inputs
    logic [1:0] swap_sync;
    logic swap_prev;
    logic [1:0] vbus_sync;
    logic [1:0] wd_sync;
    logic [1:0] lp_sync;
  } ppg_state_t;

  ppg_state_t r;
  ppg_state_t next_r;
  logic [2:0] in_level;
  logic swap_rise;
  logic swap_ready;
  logic wd_active;
  logic lp_active;

  // Offsets and registers are byte wide; other widths would break the decode
  if (ADDR_W != 8 || DATA_W != 8) begin : g_bad_width
    $error("address and data width must both be eight bits");
  end
  // The filter cannot count a zero-length window
  if (DEG_CYC < 1) begin : g_bad_deglitch
    $error("deglitch count must be at least one");
  end

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_pin
      ppg_filt_if fi ();
      assign fi.raw = pin_in[g];
      assign fi.deglitch_en = r.ctl[g][CTL_DEGLITCH];
      assign in_level[g] = fi.level;
      ppg_filter #(.CYC(DEG_CYC)) u_filt (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .f(fi.filt)
      );
    end
  endgenerate

  // Decode a command byte to the preset bit it selects
  function automatic ppg_event_t cmd_decode(input logic [7:0] c);
    unique case (c)
      CMD_DIS_SNK: cmd_decode = PPG_EV_DIS_SNK;
      CMD_ENA_SNK: cmd_decode = PPG_EV_ENA_SNK;
      CMD_DIS_SRC: cmd_decode = PPG_EV_DIS_SRC;
      CMD_ENA_SRC: cmd_decode = PPG_EV_ENA_SRC;
      CMD_ENA_HV: cmd_decode = PPG_EV_HV;
      default: cmd_decode = PPG_EV_NONE;
    endcase
  endfunction

  function automatic int preset_bit(input ppg_event_t e);
    unique case (e)
      PPG_EV_DIS_SNK: preset_bit = PRE_DIS_SNK;
      PPG_EV_ENA_SNK: preset_bit = PRE_ENA_SNK;
      PPG_EV_DIS_SRC: preset_bit = PRE_DIS_SRC;
      PPG_EV_ENA_SRC: preset_bit = PRE_ENA_SRC;
      PPG_EV_HV: preset_bit = PRE_HV;
      default: preset_bit = PRE_SWAP;
    endcase
  endfunction

  // Preset forces push-pull output at the preset level
  function automatic logic [7:0] apply_preset(input logic [7:0] c, input logic v);
    logic [7:0] t;
    t = c;
    t[CTL_DRIVE] = 1'b1;
    t[CTL_DIR] = 1'b1;
    t[CTL_OUT] = v;
    return t;
  endfunction

  // Host value for a pin control register; the input bit is status only
  function automatic logic [7:0] host_ctl(input logic [7:0] d);
    return {d[7:1], 1'b0};
  endfunction

  // Pump runs when enabled, unless told to stop in low power mode
  function automatic logic pump_on(input logic en, input logic lp_off, input logic lp);
    return en & ~(lp_off & lp);
  endfunction

  // Edge, wait condition and levels read the second stage only
  assign swap_rise = r.swap_sync[1] & ~r.swap_prev;
  assign swap_ready = ~r.opts[OPT_SWAP_WAIT] | r.vbus_sync[1];
  assign wd_active = r.wd_sync[1];
  assign lp_active = r.lp_sync[1];

  always_comb begin
    ppg_event_t ev;
    logic cmd_hit;
    logic swap_fire;
    logic [7:0] rv;
    ev = PPG_EV_NONE;
    cmd_hit = 1'b0;
    swap_fire = 1'b0;
    rv = 8'h00;
    next_r = r;
    // Every asynchronous input passes two flops before use
    next_r.swap_sync = {r.swap_sync[0], swap_event};
    next_r.swap_prev = r.swap_sync[1];
    next_r.vbus_sync = {r.vbus_sync[0], vbus_below_swap};
    next_r.wd_sync = {r.wd_sync[0], watchdog_timeout};
    next_r.lp_sync = {r.lp_sync[0], low_power_mode};

    // Host writes take effect first so a same-cycle trigger overrides them
    if (reg_wr) begin
      unique case (reg_addr)
        OFS_PIN1_PRESET: next_r.pin1_pre = reg_wdata & PRESET_MASK;
        OFS_PIN2_PRESET: next_r.pin2_pre = reg_wdata & PRESET_MASK;
        OFS_PATH_EN: next_r.path_en = reg_wdata;
        OFS_PIN1_CTRL: next_r.ctl[0] = host_ctl(reg_wdata);
        OFS_PIN2_CTRL: next_r.ctl[1] = host_ctl(reg_wdata);
        OFS_PIN3_CTRL: next_r.ctl[2] = host_ctl(reg_wdata);
        OFS_PAGE: next_r.page = reg_wdata;
        OFS_OPTIONS: next_r.opts = reg_wdata & OPTIONS_MASK;
        OFS_CMD: begin
          ev = cmd_decode(reg_wdata);
          cmd_hit = (ev != PPG_EV_NONE);
        end
        default: begin
        end
      endcase
    end

    // Swap reload, optionally held until VBUS drops
    if (swap_rise) begin
      next_r.swap_pend = 1'b1;
    end
    if ((swap_rise || r.swap_pend) && swap_ready) begin
      swap_fire = 1'b1;
      next_r.swap_pend = 1'b0;
    end
    // A later command supersedes a pending swap reload
    if (cmd_hit) begin
      next_r.swap_pend = 1'b0;
    end

    if (cmd_hit && r.path_en[EN_PIN1_RELOAD]) begin
      next_r.ctl[0] = apply_preset(next_r.ctl[0], r.pin1_pre[preset_bit(ev)]);
    end
    if (cmd_hit && r.path_en[EN_PIN2_RELOAD]) begin
      next_r.ctl[1] = apply_preset(next_r.ctl[1], r.pin2_pre[preset_bit(ev)]);
    end
    // Only pin two has a swap preset; command wins if both land together
    if (swap_fire && !cmd_hit && r.path_en[EN_PIN2_RELOAD]) begin
      next_r.ctl[1] = apply_preset(next_r.ctl[1], r.pin2_pre[PRE_SWAP]);
    end

    // Watchdog timeout restores reset defaults
    if (wd_active && r.opts[OPT_TO_PIN1]) begin
      next_r.ctl[0] = PIN_CTRL_RESET;
    end
    if (wd_active && r.opts[OPT_TO_PIN2]) begin
      next_r.ctl[1] = PIN_CTRL_RESET;
    end

    // Input bit is read-only status
    for (int i = 0; i < 3; i++) begin
      next_r.ctl[i][CTL_IN] = in_level[i];
    end

    if (reg_rd) begin
      unique case (reg_addr)
        OFS_PIN1_PRESET: rv = r.pin1_pre;
        OFS_PIN2_PRESET: rv = r.pin2_pre;
        OFS_PATH_EN: rv = r.path_en;
        OFS_PIN1_CTRL: rv = r.ctl[0];
        OFS_PIN2_CTRL: rv = r.ctl[1];
        OFS_PIN3_CTRL: rv = r.ctl[2];
        OFS_PAGE: rv = r.page;
        OFS_OPTIONS: rv = r.opts;
        default: rv = 8'h00;
      endcase
    end
    next_r.rdata = rv;
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      r.pin1_pre <= PRESET_RESET;
      r.pin2_pre <= PRESET_RESET;
      r.path_en <= PATH_EN_RESET;
      r.ctl <= {3{PIN_CTRL_RESET}};
      r.page <= PAGE_RESET;
      r.opts <= OPTIONS_RESET;
      r.swap_pend <= 1'b0;
      r.swap_sync <= 2'b00;
      r.swap_prev <= 1'b0;
      r.vbus_sync <= 2'b00;
      r.wd_sync <= 2'b00;
      r.lp_sync <= 2'b00;
      r.rdata <= 8'h00;
    end else begin
      r <= next_r;
    end
  end

  assign reg_rdata = r.rdata;

  // Pin drive: open-drain only pulls low, push-pull drives both levels
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      pin_out[i] = r.ctl[i][CTL_OUT];
      pin_oe[i] = r.ctl[i][CTL_DIR] &
                  (r.ctl[i][CTL_DRIVE] | ~r.ctl[i][CTL_OUT]);
      input_hysteresis_enable[i] = r.ctl[i][CTL_HYST];
      pull_high_enable[i] = r.ctl[i][CTL_PULL_HIGH];
      pull_low_enable[i] = r.ctl[i][CTL_PULL_LOW];
    end
  end

  assign gate_a_auto_reload_enable = r.path_en[EN_GATE_A_RELOAD];
  assign gate_b_auto_reload_enable = r.path_en[EN_GATE_B_RELOAD];
  assign gate_a_pump_enable = pump_on(r.path_en[EN_GATE_A_PUMP],
                                      r.path_en[EN_GATE_A_LPOFF], lp_active);
  assign gate_b_pump_enable = pump_on(r.path_en[EN_GATE_B_PUMP],
                                      r.path_en[EN_GATE_B_LPOFF], lp_active);
  assign second_page_select = r.page;
endmodule // ppg_gpio_reload

//--- ppg_gpio_reload_monitor.sv
// Port checker for the pin reload block
`timescale 1ns/100ps
module ppg_gpio_reload_monitor #(
  parameter int DEG_CYC = 300
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [2:0] pin_out,
  input wire logic [2:0] pin_oe,
  input wire logic [2:0] pull_high_enable,
  input wire logic [2:0] pull_low_enable,
  input wire logic [2:0] input_hysteresis_enable,
  input wire logic gate_a_auto_reload_enable,
  input wire logic gate_b_auto_reload_enable,
  input wire logic gate_a_pump_enable,
  input wire logic gate_b_pump_enable,
  input wire logic [7:0] second_page_select
);
  import ppg_pkg::*;
  logic rl1;
  logic cmd_code;
  assign cmd_code = reg_wdata inside {CMD_DIS_SNK, CMD_ENA_SNK, CMD_DIS_SRC, CMD_ENA_SRC, CMD_ENA_HV};
  // Shadow of the pin one reload enable, since reload depends on it
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rl1 <= 1'b0;
    end else if (reg_wr && reg_addr == OFS_PATH_EN) begin
      rl1 <= reg_wdata[EN_PIN1_RELOAD];
    end
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);
  sequence cmd_s;
    reg_wr && reg_addr == OFS_CMD && cmd_code;
  endsequence
  sequence pin3_wr_s;
    reg_wr && reg_addr == OFS_PIN3_CTRL;
  endsequence
  page_read_a: assert property (reg_rd && reg_addr == OFS_PAGE |=> reg_rdata == second_page_select)
    else $error("page read data wrong");
  page_write_a: assert property (reg_wr && reg_addr == OFS_PAGE |=> second_page_select == $past(reg_wdata))
    else $error("page write lost");
  page_hold_a: assert property (!(reg_wr && reg_addr == OFS_PAGE) |=> $stable(second_page_select))
    else $error("page changed without write");
  gate_reload_a: assert property (reg_wr && reg_addr == OFS_PATH_EN |=>
    gate_b_auto_reload_enable == $past(reg_wdata[5]) && gate_a_auto_reload_enable == $past(reg_wdata[4]))
    else $error("gate reload enables wrong");
  pump_off_a: assert property (reg_wr && reg_addr == OFS_PATH_EN && reg_wdata[1:0] == 2'b00 |=>
    !gate_a_pump_enable && !gate_b_pump_enable)
    else $error("pump still on");
  pin3_fields_a: assert property (pin3_wr_s |=> pull_high_enable[2] == $past(reg_wdata[5]) &&
    pull_low_enable[2] == $past(reg_wdata[4]) && input_hysteresis_enable[2] == $past(reg_wdata[6]))
    else $error("pin three input options wrong");
  pin3_drive_a: assert property (pin3_wr_s |=> pin_out[2] == $past(reg_wdata[1]) &&
    pin_oe[2] == ($past(reg_wdata[2]) && ($past(reg_wdata[3]) || !$past(reg_wdata[1]))))
    else $error("pin three drive wrong");
  reload_drive_a: assert property (cmd_s |=> pin_oe[0] || !$past(rl1))
    else $error("reload did not drive push-pull");
  reload_off_a: assert property (cmd_s |=> $stable(pin_oe[0]) || $past(rl1))
    else $error("pin changed with reload off");
endmodule // ppg_gpio_reload_monitor
bind ppg_gpio_reload ppg_gpio_reload_monitor #(.DEG_CYC(DEG_CYC)) ppg_gpio_reload_monitor_i (
  .ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_out(pin_out), .pin_oe(pin_oe),
  .pull_high_enable(pull_high_enable), .pull_low_enable(pull_low_enable),
  .input_hysteresis_enable(input_hysteresis_enable),
  .gate_a_auto_reload_enable(gate_a_auto_reload_enable),
  .gate_b_auto_reload_enable(gate_b_auto_reload_enable), .gate_a_pump_enable(gate_a_pump_enable),
  .gate_b_pump_enable(gate_b_pump_enable), .second_page_select(second_page_select));

//--- ppg_pin_model.sv
// Board model of the three pins with an external driver
`timescale 1ns/100ps
module ppg_pin_model (
  input wire logic [2:0] pin_out,
  input wire logic [2:0] pin_oe,
  input wire logic [2:0] pull_low_enable,
  input wire logic [2:0] ext_en,
  input wire logic [2:0] ext_val,
  output logic [2:0] pin_in
);
  // Board pull-up holds a released line high; internal pull-low overpowers it
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      if (pin_oe[i]) begin
        pin_in[i] = pin_out[i];
      end else if (ext_en[i]) begin
        pin_in[i] = ext_val[i];
      end else begin
        pin_in[i] = !pull_low_enable[i];
      end
    end
  end
endmodule // ppg_pin_model

//--- ppg_gpio_reload_tb_top.sv
// Self-checking bench for the pin reload block
`timescale 1ns/100ps
module ppg_gpio_reload_tb_top;
  import ppg_pkg::*;
  localparam int DEG = 20;
  localparam logic [7:0] P1 = 8'h15;
  localparam logic [7:0] P2 = 8'h4A;
  logic ref_clk, nrst, reg_wr, reg_rd, swap_event, vbus_below_swap, watchdog_timeout;
  logic low_power_mode, gate_a_pump_enable, gate_b_pump_enable;
  logic gate_a_auto_reload_enable, gate_b_auto_reload_enable;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, second_page_select;
  logic [2:0] pin_in, pin_out, pin_oe, pull_high_enable, pull_low_enable, input_hysteresis_enable;
  logic [2:0] ext_en, ext_val;
  int fails, tests_run;
  logic [7:0] adr_tab [0:6] = '{OFS_PIN2_PRESET, OFS_PATH_EN, OFS_PIN1_CTRL, OFS_PIN2_CTRL,
    OFS_PIN3_CTRL, OFS_PAGE, 8'h00};
  logic [7:0] exp_tab [0:6] = '{8'h00, 8'h3F, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] codes [0:4] = '{CMD_DIS_SNK, CMD_ENA_SNK, CMD_DIS_SRC, CMD_ENA_SRC, CMD_ENA_HV};
  ppg_gpio_reload #(.DEG_CYC(DEG)) ppg_gpio_reload_i (
    .ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .swap_event(swap_event),
    .vbus_below_swap(vbus_below_swap), .watchdog_timeout(watchdog_timeout),
    .low_power_mode(low_power_mode), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pull_high_enable(pull_high_enable), .pull_low_enable(pull_low_enable),
    .input_hysteresis_enable(input_hysteresis_enable),
    .gate_a_auto_reload_enable(gate_a_auto_reload_enable),
    .gate_b_auto_reload_enable(gate_b_auto_reload_enable), .gate_a_pump_enable(gate_a_pump_enable),
    .gate_b_pump_enable(gate_b_pump_enable), .second_page_select(second_page_select));
  ppg_pin_model ppg_pin_model_i (.pin_out(pin_out), .pin_oe(pin_oe),
    .pull_low_enable(pull_low_enable), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic pause(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("ERROR at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask
  // Generous bound: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    end_of_test();
  end
  initial begin
    {nrst, reg_wr, reg_rd, swap_event, vbus_below_swap, watchdog_timeout, low_power_mode} <= 7'h00;
    {reg_addr, reg_wdata, ext_val} <= 19'h00000;
    ext_en <= 3'h7;
    repeat (12) @(posedge ref_clk);
    nrst <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      rd(adr_tab[i], exp_tab[i]);
    end
    $display("test reset values done");
    wr(OFS_PIN3_CTRL, 8'h01);
    rd(OFS_PIN3_CTRL, 8'h00);
    wr(OFS_PIN3_CTRL, 8'h7E);
    pause(8);
    rd(OFS_PIN3_CTRL, 8'h7F);
    wr(OFS_PAGE, 8'hA5);
    rd(OFS_PAGE, 8'hA5);
    wr(8'h00, 8'hFF);
    rd(8'h00, 8'h00);
    $display("test register access done");
    wr(OFS_PIN3_CTRL, 8'h80);
    @(posedge ref_clk);
    ext_val <= 3'h4;
    pause(DEG + 10);
    rd(OFS_PIN3_CTRL, 8'h81);
    @(posedge ref_clk);
    ext_val <= 3'h0;
    pause(DEG / 2);
    rd(OFS_PIN3_CTRL, 8'h81);
    @(posedge ref_clk);
    ext_val <= 3'h4;
    pause(DEG + 10);
    rd(OFS_PIN3_CTRL, 8'h81);
    @(posedge ref_clk);
    ext_val <= 3'h0;
    pause(DEG + 10);
    rd(OFS_PIN3_CTRL, 8'h80);
    $display("test deglitch done");
    wr(OFS_CMD, CMD_ENA_SNK);
    rd(OFS_PIN1_CTRL, 8'h00);
    wr(OFS_PIN1_PRESET, P1);
    wr(OFS_PIN2_PRESET, 8'hEA);
    rd(OFS_PIN2_PRESET, P2);
    wr(OFS_PATH_EN, 8'hFF);
    for (int i = 0; i < 5; i++) begin
      wr(OFS_CMD, codes[i]);
      pause(8);
      rd(OFS_PIN1_CTRL, {6'h03, P1[i], P1[i]});
      rd(OFS_PIN2_CTRL, {6'h03, P2[i], P2[i]});
    end
    wr(OFS_PIN1_CTRL, 8'h02);
    pause(8);
    rd(OFS_PIN1_CTRL, 8'h02);
    $display("test command reload done");
    @(posedge ref_clk);
    swap_event <= 1'b1;
    pause(10);
    rd(OFS_PIN2_CTRL, 8'h0F);
    wr(OFS_OPTIONS, 8'h01);
    wr(OFS_PIN2_CTRL, 8'h00);
    @(posedge ref_clk);
    swap_event <= 1'b0;
    pause(4);
    @(posedge ref_clk);
    swap_event <= 1'b1;
    pause(10);
    rd(OFS_PIN2_CTRL, 8'h00);
    @(posedge ref_clk);
    vbus_below_swap <= 1'b1;
    pause(10);
    rd(OFS_PIN2_CTRL, 8'h0F);
    $display("test swap reload done");
    wr(OFS_OPTIONS, 8'h02);
    @(posedge ref_clk);
    watchdog_timeout <= 1'b1;
    pause(6);
    @(posedge ref_clk);
    watchdog_timeout <= 1'b0;
    pause(6);
    rd(OFS_PIN1_CTRL, 8'h00);
    rd(OFS_PIN2_CTRL, 8'h0F);
    $display("test watchdog default done");
    wr(OFS_PATH_EN, 8'h03);
    @(posedge ref_clk);
    low_power_mode <= 1'b1;
    pause(6);
    chk({6'h00, gate_b_pump_enable, gate_a_pump_enable}, 8'h03);
    wr(OFS_PATH_EN, 8'h0B);
    pause(1);
    chk({6'h00, gate_b_pump_enable, gate_a_pump_enable}, 8'h01);
    @(posedge ref_clk);
    low_power_mode <= 1'b0;
    pause(6);
    chk({6'h00, gate_b_pump_enable, gate_a_pump_enable}, 8'h03);
    wr(OFS_PATH_EN, 8'h0C);
    pause(1);
    chk({6'h00, gate_b_pump_enable, gate_a_pump_enable}, 8'h00);
    $display("test charge pumps done");
    end_of_test();
  end
endmodule // ppg_gpio_reload_tb_top
